// ==== exo_pkg.sv ====
`default_nettype none
package exo_pkg;

  // Reset (power-on) values of the mode bits that steer this block
  localparam logic MODE_SELECT_RST   = 1'b0;
  localparam logic MODE_AUX_HI_RST   = 1'b0;
  localparam logic MODE_AUX_LO_RST   = 1'b0;
  localparam logic MODE_ALT_EXC_RST  = 1'b0;
  localparam logic MODE_CHOP_RST     = 1'b0;

  // Resting levels of the excitation pair
  localparam logic PHASE_REST_LEVEL  = 1'b1;
  localparam logic PHASE_N_REST      = 1'b0;

  // Non-overlap gap length in master clock cycles
  localparam int   GAP_CYCLES        = 1;

  // Mode bits as written over the serial interface
  typedef struct packed {
    logic aux_output_select;
    logic aux_output_high_bit;
    logic aux_output_low_bit;
    logic alternating_excitation_mode;
    logic chopping_mode;
  } exo_mode_type;

  // One tri-state pin as output and enable
  typedef struct packed {
    logic out;
    logic oe;
  } exo_pin_type;

  typedef enum logic [1:0] {
    EXO_REST,
    EXO_NORMAL,
    EXO_GAP,
    EXO_REVERSED
  } exo_state_type;

endpackage
`default_nettype wire

// ==== exo_aux_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
module exo_aux_pins
  import exo_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Mode bits
  input  wire exo_mode_type mode,
  // Pin drive
  output exo_pin_type       secondary_input_pos_pin,
  output exo_pin_type       secondary_input_neg_pin
);

  exo_pin_type pos_ff, neg_ff, nxt_pos, nxt_neg;

  // Pins only driven in digital-output mode, else left to the analog front end
  always_comb begin
    nxt_pos.oe  = mode.aux_output_select;                        // R1
    nxt_neg.oe  = mode.aux_output_select;                        // R10
    nxt_pos.out = mode.aux_output_select & mode.aux_output_high_bit; // R2
    nxt_neg.out = mode.aux_output_select & mode.aux_output_low_bit;  // R3
  end

  // Registered so pins never glitch on mode writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pos_ff <= '0; // R9
      neg_ff <= '0;
    end else begin
      pos_ff <= nxt_pos;
      neg_ff <= nxt_neg;
    end
  end

  assign secondary_input_pos_pin = pos_ff;
  assign secondary_input_neg_pin = neg_ff;

  a_aux_hi_follows: assert property (@(posedge core_clk) disable iff (reset) // R2
    mode.aux_output_select |=> secondary_input_pos_pin.oe &&
      secondary_input_pos_pin.out == $past(mode.aux_output_high_bit))
    else $error("aux high pin does not follow its bit");
  a_aux_lo_follows: assert property (@(posedge core_clk) disable iff (reset) // R3
    mode.aux_output_select |=> secondary_input_neg_pin.oe &&
      secondary_input_neg_pin.out == $past(mode.aux_output_low_bit))
    else $error("aux low pin does not follow its bit");
  a_aux_undriven: assert property (@(posedge core_clk) disable iff (reset) // R10
    !mode.aux_output_select |=> !secondary_input_pos_pin.oe && !secondary_input_neg_pin.oe)
    else $error("aux pins driven in analog mode");
  c_aux_on: cover property (@(posedge core_clk) disable iff (reset)
    secondary_input_pos_pin.oe && secondary_input_pos_pin.out);

endmodule
`default_nettype wire

// ==== exo_excitation.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Output-select mode bit chooses analog pair or two digital outputs.
// R2: In digital mode, positive secondary pin drives the high aux bit.
// R3: In digital mode, negative secondary pin drives the low aux bit.
// R4: Phase output high means normal excitation, low means reversed.
// R5: Phase output stays high when alternating or chopping mode is off.
// R6: Inverted phase output is the complement, toggling in anti-phase.
// R7: Inverted phase output stays low when alternating or chopping is off.
// R8: Never both high; each toggle has exactly one cycle both low.
// R9: Reset returns mode bits and all outputs to power-on state.
// R10: Outside digital mode, secondary pins are left undriven.
module exo_excitation
  import exo_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Mode register write port
  input  wire logic         mode_write,
  input  wire exo_mode_type mode_wdata,
  // Phase toggle request from conversion sequencing
  input  wire logic         phase_toggle,
  // Mode readback
  output exo_mode_type      mode_bits,
  // Excitation pair
  output logic              excitation_phase,
  output logic              excitation_phase_n,
  // Secondary input pins
  output exo_pin_type       secondary_input_pos_pin,
  output exo_pin_type       secondary_input_neg_pin
);

  localparam exo_mode_type MODE_RST = '{MODE_SELECT_RST, MODE_AUX_HI_RST, MODE_AUX_LO_RST,
                                        MODE_ALT_EXC_RST, MODE_CHOP_RST};

  exo_mode_type  mode_ff, nxt_mode;
  exo_state_type state_ff, nxt_state;
  logic          gap_to_rev_ff, nxt_gap_to_rev;
  logic          phase_ff, nxt_phase;
  logic          phase_n_ff, nxt_phase_n;
  logic          toggling;
  logic [1:0]    gap_len_ff, nxt_gap_len;

  // Both alternating and chopping must be on before the pair may leave rest
  // Either bit alone off parks the pair, whatever the toggle input does
  assign toggling = mode_ff.alternating_excitation_mode & mode_ff.chopping_mode;

  // Mode bits
  always_comb begin
    nxt_mode = mode_write ? mode_wdata : mode_ff;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_ff <= MODE_RST; // R9
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Phase sequencer; a toggle request during the gap is absorbed, the gap is fixed
  always_comb begin
    nxt_state      = state_ff;
    nxt_gap_to_rev = gap_to_rev_ff;
    unique case (state_ff)
      EXO_REST: begin
        if (toggling && phase_toggle) begin
          nxt_state      = EXO_GAP; // R8
          nxt_gap_to_rev = 1'b1;
        end else if (toggling) begin
          nxt_state = EXO_NORMAL;
        end
      end
      EXO_NORMAL: begin
        if (!toggling) begin
          nxt_state = EXO_REST; // R5
        end else if (phase_toggle) begin
          nxt_state      = EXO_GAP; // R8
          nxt_gap_to_rev = 1'b1;
        end
      end
      EXO_REVERSED: begin
        if (!toggling) begin
          nxt_state = EXO_REST; // R5
        end else if (phase_toggle) begin
          nxt_state      = EXO_GAP; // R8
          nxt_gap_to_rev = 1'b0;
        end
      end
      EXO_GAP: begin
        if (!toggling) begin
          nxt_state = EXO_REST;
        end else begin
          nxt_state = gap_to_rev_ff ? EXO_REVERSED : EXO_NORMAL;
        end
      end
    endcase
  end

  // Outputs are decoded from the next state so they are registered
  always_comb begin
    nxt_phase   = PHASE_REST_LEVEL;
    nxt_phase_n = PHASE_N_REST;
    unique case (nxt_state)
      EXO_REST: begin
        nxt_phase   = PHASE_REST_LEVEL; // R5
        nxt_phase_n = PHASE_N_REST;     // R7
      end
      EXO_NORMAL: begin
        nxt_phase   = 1'b1; // R4
        nxt_phase_n = 1'b0; // R6
      end
      EXO_REVERSED: begin
        nxt_phase   = 1'b0; // R4
        nxt_phase_n = 1'b1; // R6
      end
      EXO_GAP: begin
        nxt_phase   = 1'b0; // R8
        nxt_phase_n = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff      <= EXO_REST; // R9
      gap_to_rev_ff <= 1'b0;
      phase_ff      <= PHASE_REST_LEVEL;
      phase_n_ff    <= PHASE_N_REST;
    end else begin
      state_ff      <= nxt_state;
      gap_to_rev_ff <= nxt_gap_to_rev;
      phase_ff      <= nxt_phase;
      phase_n_ff    <= nxt_phase_n;
    end
  end

  // Gap watch for the checks below; a stalled gap is caught long before the wrap
  always_comb begin
    nxt_gap_len = 2'h0;
    if (state_ff == EXO_GAP) begin
      nxt_gap_len = gap_len_ff + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gap_len_ff <= 2'h0;
    end else begin
      gap_len_ff <= nxt_gap_len;
    end
  end

  // Leaving reversed for rest swaps both outputs on one edge; no gap is spent
  // there since the inverted output only falls, so the switches never overlap
  assign mode_bits          = mode_ff;
  assign excitation_phase   = phase_ff;
  assign excitation_phase_n = phase_n_ff;

  // Secondary pin drivers
  exo_aux_pins u_aux (
    .core_clk                (core_clk),
    .reset                   (reset),
    .mode                    (mode_ff),
    .secondary_input_pos_pin (secondary_input_pos_pin),
    .secondary_input_neg_pin (secondary_input_neg_pin)
  );

  // Checks
  a_no_overlap: assert property (@(posedge core_clk) disable iff (reset) // R8
    !(excitation_phase && excitation_phase_n))
    else $error("both excitation outputs high");
  a_gap_one_cycle: assert property (@(posedge core_clk) disable iff (reset) // R8
    (!excitation_phase && !excitation_phase_n && toggling) |=>
      (excitation_phase ^ excitation_phase_n) || !$past(toggling) || !toggling)
    else $error("non-overlap gap not one cycle");
  a_gap_length: assert property (@(posedge core_clk) disable iff (reset) // R8
    state_ff == EXO_GAP |-> gap_len_ff < GAP_CYCLES)
    else $error("non-overlap gap too long");
  a_gap_before_rise: assert property (@(posedge core_clk) disable iff (reset) // R8
    $rose(excitation_phase_n) |-> $past(!excitation_phase && !excitation_phase_n))
    else $error("inverted output rose without gap");
  // A rise after reset or after mode off is a return to rest, not a toggle
  a_gap_before_phase: assert property (@(posedge core_clk) disable iff (reset) // R8
    $rose(excitation_phase) && $past(toggling) && !$past(reset) |->
      $past(!excitation_phase && !excitation_phase_n))
    else $error("phase output rose without gap");
  a_rest_levels: assert property (@(posedge core_clk) disable iff (reset) // R5
    !toggling |=> excitation_phase && !excitation_phase_n)
    else $error("pair not at rest when mode off");
  a_rest_inverted: assert property (@(posedge core_clk) disable iff (reset) // R7
    (!toggling)[*2] |-> !excitation_phase_n)
    else $error("inverted output not low at rest");
  a_complement_on: assert property (@(posedge core_clk) disable iff (reset) // R6
    (state_ff == EXO_NORMAL || state_ff == EXO_REVERSED) |->
      excitation_phase == !excitation_phase_n)
    else $error("pair not complementary");
  a_toggle_sequence: assert property (@(posedge core_clk) disable iff (reset) // R4
    (state_ff == EXO_NORMAL && toggling && phase_toggle) ##1 toggling |=>
      !excitation_phase && excitation_phase_n)
    else $error("toggle did not reach reversed phase");
  a_toggle_back: assert property (@(posedge core_clk) disable iff (reset) // R4
    (state_ff == EXO_REVERSED && toggling && phase_toggle) ##1 toggling |=>
      excitation_phase && !excitation_phase_n)
    else $error("toggle did not return to normal phase");
  a_start_normal: assert property (@(posedge core_clk) disable iff (reset) // R4
    state_ff == EXO_REST && !phase_toggle |=> excitation_phase && !excitation_phase_n)
    else $error("pair did not start in normal phase");
  a_mode_load: assert property (@(posedge core_clk) disable iff (reset) // R1
    mode_write |=> mode_bits == $past(mode_wdata))
    else $error("mode bits did not take the written value");
  a_reset_rest: assert property (@(posedge core_clk) // R9
    reset |=> excitation_phase && !excitation_phase_n && mode_bits == MODE_RST)
    else $error("reset did not restore power-on state");

  c_reversed: cover property (@(posedge core_clk) disable iff (reset)
    excitation_phase_n);
  c_gap: cover property (@(posedge core_clk) disable iff (reset)
    state_ff == EXO_GAP);
  c_toggle_in_gap: cover property (@(posedge core_clk) disable iff (reset)
    state_ff == EXO_GAP && toggling && phase_toggle);
  c_back_normal: cover property (@(posedge core_clk) disable iff (reset)
    excitation_phase_n ##1 !excitation_phase_n ##1 excitation_phase);

endmodule
`default_nettype wire

// ==== exo_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module exo_load_model
  import exo_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Bridge switch drive
  input  wire logic        excitation_phase,
  input  wire logic        excitation_phase_n,
  // Secondary pins
  input  wire exo_pin_type pos_pin,
  input  wire exo_pin_type neg_pin,
  // Resolved levels and fault flag
  output logic             pos_level,
  output logic             neg_level,
  output logic             overlap_seen
);
  logic wiggle = 1'b0;
  // Undriven pin shows a moving analog level, so a stale value never passes
  always @(posedge core_clk) wiggle <= ~wiggle;
  assign pos_level = pos_pin.oe ? pos_pin.out : wiggle;
  assign neg_level = neg_pin.oe ? neg_pin.out : ~wiggle;
  // Both switches closed would short the bridge supply
  initial overlap_seen = 1'b0;
  always @(posedge core_clk) if (excitation_phase && excitation_phase_n) overlap_seen <= 1'b1;
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import exo_pkg::*;
  logic core_clk, reset, mode_write, phase_toggle, pos_level, neg_level, overlap_seen;
  logic [4:0] mode_wdata;
  exo_mode_type mode_bits;
  logic excitation_phase, excitation_phase_n;
  exo_pin_type pos_pin, neg_pin;
  int failures = 0;
  int samples_checked = 0;
  typedef struct {logic [4:0] m; logic [1:0] p; logic [1:0] n;} exo_row_type;
  // Mode value {select,hi,lo,alt,chop} beside expected {out,oe} of each pin
  exo_row_type rows [6] = '{'{5'h10, 2'h1, 2'h1}, '{5'h14, 2'h1, 2'h3},
    '{5'h18, 2'h3, 2'h1}, '{5'h1c, 2'h3, 2'h3}, '{5'h0c, 2'h0, 2'h0}, '{5'h1f, 2'h3, 2'h3}};

  exo_excitation u_dut (.core_clk(core_clk), .reset(reset), .mode_write(mode_write),
    .mode_wdata(mode_wdata), .phase_toggle(phase_toggle), .mode_bits(mode_bits),
    .excitation_phase(excitation_phase), .excitation_phase_n(excitation_phase_n),
    .secondary_input_pos_pin(pos_pin), .secondary_input_neg_pin(neg_pin));
  exo_load_model u_load (.core_clk(core_clk), .excitation_phase(excitation_phase),
    .excitation_phase_n(excitation_phase_n), .pos_pin(pos_pin), .neg_pin(neg_pin),
    .pos_level(pos_level), .neg_level(neg_level), .overlap_seen(overlap_seen));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (e !== s) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Pulse and wait until pins have settled (one edge after the taking edge)
  task automatic wr(input logic [4:0] m);
    @(posedge core_clk) begin mode_write <= 1'b1; mode_wdata <= m; end
    @(posedge core_clk) mode_write <= 1'b0;
    @(posedge core_clk) #1;
  endtask

  task automatic tog();
    @(posedge core_clk) phase_toggle <= 1'b1;
    @(posedge core_clk) phase_toggle <= 1'b0;
  endtask

  // Waits for the gap, checks it is one cycle, then checks the new phase
  task automatic gap_to(input logic ph);
    int k;
    #1;
    for (k = 0; k < 4 && (excitation_phase || excitation_phase_n); k++) @(posedge core_clk) #1;
    chk("gap", 8'h0, {excitation_phase, excitation_phase_n});
    @(posedge core_clk) #1;
    chk("phase", {7'h0, ph}, excitation_phase);
    chk("phase_n", {7'h0, ~ph}, excitation_phase_n);
  endtask

  task automatic rst_chk();
    chk("rst_mode", 8'h0, mode_bits);
    chk("rst_pair", 8'h2, {excitation_phase, excitation_phase_n});
    chk("rst_pins", 8'h0, {pos_pin, neg_pin});
  endtask

  task automatic end_sim();
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    failures++;
    end_sim();
  end

  initial begin
    reset = 1'b1;
    mode_write = 1'b0;
    phase_toggle = 1'b0;
    mode_wdata = 5'h00;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    #1 rst_chk();
    foreach (rows[i]) begin
      wr(rows[i].m);
      chk("mode", {3'h0, rows[i].m}, mode_bits);
      chk("pos", {6'h0, rows[i].p}, pos_pin);
      chk("neg", {6'h0, rows[i].n}, neg_pin);
      if (rows[i].p[0]) chk("pos_lvl", {7'h0, rows[i].p[1]}, pos_level);
      if (rows[i].n[0]) chk("neg_lvl", {7'h0, rows[i].n[1]}, neg_level);
    end
    // Toggling to reversed and back to normal, each request sampled once outside the gap
    chk("normal", 8'h2, {excitation_phase, excitation_phase_n});
    tog();
    gap_to(1'b0);
    tog();
    gap_to(1'b1);
    // Request held across the gap cycle: its second sample must be absorbed
    @(posedge core_clk) phase_toggle <= 1'b1;
    repeat (2) @(posedge core_clk);
    phase_toggle <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk("gap_refused", 8'h1, {excitation_phase, excitation_phase_n});
    // Alternating or chopping bit alone off drops the pair back to rest, toggles refused
    foreach (rows[i]) if (i < 2) begin
      wr(5'h1f);
      tog();
      gap_to(i ? 1'b0 : 1'b1);
      wr(i ? 5'h1e : 5'h1d);
      chk("rest", 8'h2, {excitation_phase, excitation_phase_n});
      tog();
      repeat (3) @(posedge core_clk);
      #1 chk("off_refused", 8'h2, {excitation_phase, excitation_phase_n});
    end
    // Reset in mid-run while reversed
    wr(5'h1f);
    tog();
    gap_to(1'b0);
    @(posedge core_clk) reset <= 1'b1;
    @(posedge core_clk) reset <= 1'b0;
    #1 rst_chk();
    wr(5'h18);
    chk("post_rst", 8'h3, pos_pin);
    chk("overlap", 8'h0, overlap_seen);
    end_sim();
  end
endmodule
`default_nettype wire
